// *** rtl/pbs_pkg.sv ***
// package of constants and types for the pushbutton power sequencer
package pbs_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICK_W = 16;
  localparam int unsigned DEBOUNCE_MS = 32;
  localparam int unsigned BLANK_MS = 512;
  localparam int unsigned OFF_DELAY_MS = 1024;
  localparam int unsigned LOCKOUT_MS = 256;
  localparam int unsigned KILL_PW_US = 30;
  localparam int unsigned CNT_W = 12;
  localparam int unsigned EXT_W = 8;
  localparam logic [CNT_W-1:0] DEBOUNCE_TICKS = CNT_W'(DEBOUNCE_MS / TICK_MS);
  localparam logic [CNT_W-1:0] BLANK_TICKS = CNT_W'(BLANK_MS / TICK_MS);
  localparam logic [CNT_W-1:0] OFF_DELAY_TICKS = CNT_W'(OFF_DELAY_MS / TICK_MS);
  localparam logic [CNT_W-1:0] LOCKOUT_TICKS = CNT_W'(LOCKOUT_MS / TICK_MS);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  typedef enum logic [2:0] {
    PBS_OFF = 3'b000,
    PBS_ON_DB = 3'b001,
    PBS_BLANK = 3'b011,
    PBS_REL_DB = 3'b010,
    PBS_RUN = 3'b110,
    PBS_OFF_DB = 3'b111,
    PBS_SHUT = 3'b101,
    PBS_LOCK = 3'b100
  } pbs_state_t;
endpackage

// *** rtl/pbs_tick_if.sv ***
`timescale 1ns/10ps
// interface carrying the millisecond tick between prescaler and sequencer
interface pbs_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

// *** rtl/pbs_prescaler.sv ***
`timescale 1ns/10ps
// millisecond tick prescaler
module pbs_prescaler
  import pbs_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYC
)
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  pbs_tick_if.src tk
);
  localparam logic [TICK_W-1:0] DIV_LAST = TICK_W'(TICK_DIV - 1);
  logic [TICK_W-1:0] div;
  logic tick;

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      div <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (div == DIV_LAST);
      div <= (div == DIV_LAST) ? '0 : div + 1'b1;
    end
  end
  assign tk.tick = tick;

  tick_period_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    tick |=> !tick [*2]) else $error("tick repeated too soon");
endmodule

// *** rtl/pbs_sequencer.sv ***
`timescale 1ns/10ps
// pushbutton power on/off sequencer top
// Function
// - turn-off needs button low 32 ms plus extension before shutdown request
// - turn-on needs button low 32 ms plus extension
// - valid turn-on asserts power enable, polarity set by parameter
// - 512 ms blanking starts as enable asserts, excluding debounce
// - kill and button are ignored during blanking
// - kill still low at blanking end releases enable
// - valid turn-off press drives shutdown request low
// - shutdown timeout starts when request falls, excluding debounce
// - kill low during timeout releases enable at once
// - kill high at 1024 ms timeout end releases enable
// - outside blanking, kill low releases enable any time
// - button ignored for a lockout period after release
// - lockout lasts 256 ms, button disregarded throughout
// - button high during a press debounce restarts it; button low restarts a release debounce
// - after blanking and turn-off, button release debounced 32 ms
// - at power-up enable is off and request released
module pbs_sequencer
  import pbs_pkg::*;
#(
  parameter bit EN_ACTIVE_HIGH = 1'b1,
  // clocks per timer tick; a bench may shorten it to run whole sequences quickly
  parameter int unsigned TICK_DIV = TICK_CYC
)
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_button_n,
  input wire logic i_kill_n,
  input wire logic [EXT_W-1:0] i_on_time_extend,
  input wire logic [EXT_W-1:0] i_off_time_extend,
  output logic o_power_en,
  output logic o_shdn_req_n_out,
  output logic o_shdn_req_n_oe
);
  pbs_tick_if tk ();
  pbs_state_t state;
  pbs_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic en_on;
  logic lost;

  pbs_prescaler #(.TICK_DIV(TICK_DIV)) u_pre (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .tk(tk)
  );

  // ticks needed: base plus a configured extension in whole milliseconds
  function automatic logic [CNT_W-1:0] db_len(input logic [EXT_W-1:0] ext);
    db_len = DEBOUNCE_TICKS + CNT_W'(ext);
  endfunction

  // kill is released immediately in the powered states after blanking, sampled per clock
  assign lost = !i_kill_n;

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      PBS_OFF:
        if (!i_button_n)
        begin
          next_state = PBS_ON_DB;
          next_cnt = '0;
        end
      PBS_ON_DB:
        if (i_button_n)
          next_state = PBS_OFF;
        else if (tk.tick)
        begin
          next_cnt = cnt + 1'b1;
          if (cnt + 1'b1 >= db_len(i_on_time_extend))
          begin
            next_state = PBS_BLANK;
            next_cnt = '0;
          end
        end
      PBS_BLANK:
        if (tk.tick)
        begin
          next_cnt = cnt + 1'b1;
          if (cnt + 1'b1 >= BLANK_TICKS)
          begin
            next_cnt = '0;
            next_state = lost ? PBS_LOCK : PBS_REL_DB;
          end
        end
      PBS_REL_DB:
        if (lost)
        begin
          next_state = PBS_LOCK;
          next_cnt = '0;
        end
        else if (!i_button_n)
          next_cnt = '0;
        else if (tk.tick)
        begin
          next_cnt = cnt + 1'b1;
          if (cnt + 1'b1 >= DEBOUNCE_TICKS)
            next_state = PBS_RUN;
        end
      PBS_RUN:
        if (lost)
        begin
          next_state = PBS_LOCK;
          next_cnt = '0;
        end
        else if (!i_button_n)
        begin
          next_state = PBS_OFF_DB;
          next_cnt = '0;
        end
      PBS_OFF_DB:
        if (lost)
        begin
          next_state = PBS_LOCK;
          next_cnt = '0;
        end
        else if (i_button_n)
          next_state = PBS_RUN;
        else if (tk.tick)
        begin
          next_cnt = cnt + 1'b1;
          if (cnt + 1'b1 >= db_len(i_off_time_extend))
          begin
            next_state = PBS_SHUT;
            next_cnt = '0;
          end
        end
      PBS_SHUT:
        if (lost)
        begin
          next_state = PBS_LOCK;
          next_cnt = '0;
        end
        else if (tk.tick)
        begin
          next_cnt = cnt + 1'b1;
          if (cnt + 1'b1 >= OFF_DELAY_TICKS)
          begin
            next_state = PBS_LOCK;
            next_cnt = '0;
          end
        end
      PBS_LOCK:
        // the button is not looked at until the lockout has run; then its release is
        // debounced, so a press held through turn-off cannot start a new power-up
        if (cnt >= LOCKOUT_TICKS && !i_button_n)
          next_cnt = LOCKOUT_TICKS;
        else if (tk.tick)
        begin
          next_cnt = cnt + 1'b1;
          if (cnt + 1'b1 >= LOCKOUT_TICKS + DEBOUNCE_TICKS)
          begin
            next_state = PBS_OFF;
            next_cnt = '0;
          end
        end
      default:
      begin
        next_state = PBS_OFF;
        next_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      state <= PBS_OFF;
      cnt <= '0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  assign en_on = (next_state == PBS_BLANK) || (next_state == PBS_REL_DB) ||
                 (next_state == PBS_RUN) || (next_state == PBS_OFF_DB) ||
                 (next_state == PBS_SHUT);

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
      o_power_en <= !EN_ACTIVE_HIGH;
    else
      o_power_en <= en_on ? EN_ACTIVE_HIGH : !EN_ACTIVE_HIGH;
  end

  // open drain: only ever drives low, so output data stays zero
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      o_shdn_req_n_out <= 1'b0;
      o_shdn_req_n_oe <= 1'b0;
    end
    else
    begin
      o_shdn_req_n_out <= 1'b0;
      o_shdn_req_n_oe <= (next_state == PBS_SHUT);
    end
  end

  sequence s_blank_entry;
    state == PBS_ON_DB && next_state == PBS_BLANK;
  endsequence

  en_on_turnon_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    s_blank_entry |=> o_power_en == EN_ACTIVE_HIGH)
    else $error("enable not asserted after turn-on");
  blank_ignores_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    state == PBS_BLANK && !tk.tick |=> state == PBS_BLANK)
    else $error("blanking left without tick");
  abort_on_kill_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    state == PBS_BLANK && next_state != PBS_BLANK && lost |=> state == PBS_LOCK)
    else $error("power-up not aborted");
  kill_release_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (state == PBS_RUN || state == PBS_SHUT) && lost
    |=> o_power_en == !EN_ACTIVE_HIGH)
    else $error("kill did not release enable");
  req_low_shut_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    state == PBS_OFF_DB && next_state == PBS_SHUT |=> o_shdn_req_n_oe)
    else $error("shutdown request not driven");
  req_follows_en_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_power_en == !EN_ACTIVE_HIGH |-> !o_shdn_req_n_oe)
    else $error("request held with power off");
  lock_no_button_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    state == PBS_LOCK && cnt + 1'b1 < LOCKOUT_TICKS |=> state == PBS_LOCK)
    else $error("lockout ended early");
  lock_rel_db_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    state == PBS_LOCK && cnt >= LOCKOUT_TICKS && !i_button_n
    |=> state == PBS_LOCK && cnt == LOCKOUT_TICKS)
    else $error("release debounce not restarted");
  shut_timeout_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    state == PBS_SHUT && tk.tick && cnt == OFF_DELAY_TICKS - 1'b1
    |=> state == PBS_LOCK)
    else $error("shutdown timeout missed");
  ondb_restart_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    state == PBS_ON_DB && i_button_n |=> state == PBS_OFF)
    else $error("debounce not restarted");
endmodule

// *** tb/pbs_host_model.sv ***
`timescale 1ns/10ps
// host processor model driving the kill line of the sequencer
module pbs_host_model (
  input wire logic i_mclk,
  input wire logic i_hold_low,
  input wire logic i_req_to_kill,
  input wire logic i_shdn_req_n_oe,
  output logic o_kill_n
);
  // kill is held low for hundreds of ticks under hold_low, but for only one clock when tied to the request
  always_ff @(negedge i_mclk)
  begin
    o_kill_n <= !(i_hold_low || (i_req_to_kill && i_shdn_req_n_oe));
  end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/10ps
// self-checking testbench for the pushbutton power sequencer
`define CHK(name, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("ERROR %s expected %0h seen %0h", name, exp, got); \
    end \
  end
module tb;
  import pbs_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_button_n = 1'b1;
  logic hold_low = 1'b0;
  logic req_to_kill = 1'b0;
  logic [EXT_W-1:0] on_ext = 8'h00;
  logic [EXT_W-1:0] off_ext = 8'h00;
  // short tick keeps the full on/off sequence within a few tens of thousands of clocks
  localparam int TB_TICK = 10;
  logic kill_n;
  logic o_power_en;
  logic o_shdn_req_n_out;
  logic o_shdn_req_n_oe;
  int num_errors = 0;
  int n_compared = 0;

  always #12.5 i_mclk = ~i_mclk;

  pbs_sequencer #(.EN_ACTIVE_HIGH(1'b1), .TICK_DIV(TB_TICK)) DUT (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_button_n(i_button_n),
    .i_kill_n(kill_n),
    .i_on_time_extend(on_ext),
    .i_off_time_extend(off_ext),
    .o_power_en(o_power_en),
    .o_shdn_req_n_out(o_shdn_req_n_out),
    .o_shdn_req_n_oe(o_shdn_req_n_oe)
  );

  pbs_host_model host (
    .i_mclk(i_mclk),
    .i_hold_low(hold_low),
    .i_req_to_kill(req_to_kill),
    .i_shdn_req_n_oe(o_shdn_req_n_oe),
    .o_kill_n(kill_n)
  );

  // one unit here is one timer tick of the design
  task automatic wait_ms(input int ms);
    repeat (ms * TB_TICK) @(negedge i_mclk);
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check_reset;
    `CHK("power_en", 1'b0, o_power_en)
    `CHK("shdn_oe", 1'b0, o_shdn_req_n_oe)
  endtask

  // a bounce in mid-debounce must push enable a full debounce later
  task automatic turn_on_restart;
    i_button_n = 1'b0;
    wait_ms(20);
    i_button_n = 1'b1;
    wait_ms(1);
    i_button_n = 1'b0;
    wait_ms(30);
    `CHK("power_en", 1'b0, o_power_en)
    wait_ms(3);
    `CHK("power_en", 1'b1, o_power_en)
  endtask

  // kill low through blanking and button held until near its end, then abort at its end
  task automatic blank_abort;
    hold_low = 1'b1;
    wait_ms(490);
    `CHK("power_en", 1'b1, o_power_en)
    `CHK("shdn_oe", 1'b0, o_shdn_req_n_oe)
    i_button_n = 1'b1;
    wait_ms(25);
    `CHK("power_en", 1'b0, o_power_en)
    `CHK("shdn_oe", 1'b0, o_shdn_req_n_oe)
  endtask

  // a long press inside the lockout must not power up
  task automatic lockout_press;
    hold_low = 1'b0;
    i_button_n = 1'b0;
    wait_ms(100);
    `CHK("power_en", 1'b0, o_power_en)
    wait_ms(160);
    i_button_n = 1'b1;
  endtask

  // press held past lockout must not restart; extensions stretch both debounces
  task automatic off_timeout;
    on_ext = 8'h05;
    off_ext = 8'h0a;
    wait_ms(40);
    `CHK("power_en", 1'b0, o_power_en)
    i_button_n = 1'b0;
    wait_ms(36);
    `CHK("power_en", 1'b0, o_power_en)
    wait_ms(2);
    `CHK("power_en", 1'b1, o_power_en)
    i_button_n = 1'b1;
    wait_ms(553);
    i_button_n = 1'b0;
    wait_ms(41);
    `CHK("shdn_oe", 1'b0, o_shdn_req_n_oe)
    wait_ms(2);
    `CHK("shdn_oe", 1'b1, o_shdn_req_n_oe)
    `CHK("shdn_out", 1'b0, o_shdn_req_n_out)
    i_button_n = 1'b1;
    wait_ms(1022);
    `CHK("power_en", 1'b1, o_power_en)
    wait_ms(2);
    `CHK("power_en", 1'b0, o_power_en)
    `CHK("shdn_oe", 1'b0, o_shdn_req_n_oe)
  endtask

  // request tied to kill: the turn-off press itself releases power at once
  task automatic kill_tie;
    on_ext = 8'h00;
    off_ext = 8'h00;
    req_to_kill = 1'b1;
    wait_ms(290);
    i_button_n = 1'b0;
    wait_ms(33);
    `CHK("power_en", 1'b1, o_power_en)
    i_button_n = 1'b1;
    wait_ms(550);
    i_button_n = 1'b0;
    wait_ms(33);
    `CHK("power_en", 1'b0, o_power_en)
    `CHK("shdn_oe", 1'b0, o_shdn_req_n_oe)
    i_button_n = 1'b1;
  endtask

  initial
  begin
    repeat (6) @(negedge i_mclk);
    check_reset();
    i_rst_b = 1'b1;
    turn_on_restart();
    blank_abort();
    lockout_press();
    off_timeout();
    kill_tie();
    tally_and_finish();
  end

  // whole sequence is about 3440 ticks, some 860 us of simulated time
  initial
  begin
    #(1_000_000);
    num_errors++;
    tally_and_finish();
  end
endmodule
